// file: verilog/fpmd_panel_ctrl.sv
`timescale 1ns/1ps
// How it works
// - A new warning or fault at once switches to warning display, never otherwise.
// - In warning display any key press returns to the mode shown before.
// - Twenty seconds without keys in a selection or edit mode returns the display to status monitoring.
// - Holding set in status monitoring toggles the lock; locked keys change no setting, only the page.
// - Power-up shows status monitoring of the chosen item, motor speed by default.
// - Short set while editing returns to parameter selection and drops the edit.
// - Held set while editing writes the working parameter, never nonvolatile storage.
// - While the host software is connected, parameter setting cannot be entered.
// - Each short mode press while editing moves the cursor one digit left, except from digit 9, where it wraps back to digit 0.
// - Up and down step monitor codes, functions, parameters and edited digits.
// - Five seven-segment digits show status, warning codes and parameter values.
// - Holding mode cycles monitoring, function and parameter selection modes.
// - Short set enters or confirms; held set saves or executes the setting.
// - Negative values down to -9999 show a minus in the leftmost digit.
// - Values of -10000 or below use no digit for the minus sign.
// - Over five digits: flashing leftmost digit marks lower page; a key shows upper.
// - Lock or unlock needs the key held one second in status monitoring.
// - Saving while the motor turns is refused as busy; it succeeds only stopped.
module fpmd_panel_ctrl #(
  parameter longint unsigned TIMEOUT_CYC = fpmd_pkg::TIMEOUT_CYC,
  parameter longint unsigned HOLD_CYC = fpmd_pkg::HOLD_CYC,
  parameter longint unsigned DEB_CYC = fpmd_pkg::DEB_CYC,
  parameter longint unsigned BLINK_CYC = fpmd_pkg::BLINK_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Key pins, high while pressed
  input wire logic [fpmd_pkg::NKEYS-1:0] keysPressed,
  // Drive status
  input wire logic alarmActive,
  input wire logic [7:0] alarmCode,
  input wire logic hostConnected,
  input wire logic motorMoving,
  input wire logic [31:0] monValue,
  input wire logic [31:0] paramRdValue,
  // Selections
  output logic [4:0] monSel,
  output logic [3:0] funcSel,
  output logic [6:0] paramSel,
  // Parameter and function requests
  output fpmd_pkg::fpmd_pwr_t paramWr,
  output logic saveReq,
  output logic saveBusy,
  output logic funcExec,
  // Panel state and display
  output fpmd_pkg::fpmd_mode_t dispMode,
  output logic panelLocked,
  output fpmd_pkg::fpmd_seg_t segments
);
  import fpmd_pkg::*;

  typedef struct packed {
    fpmd_mode_t mode;
    fpmd_mode_t prevMode;
    logic [4:0] monSel;
    logic [3:0] funcSel;
    logic [6:0] paramSel;
    logic locked;
    logic pageHigh;
    logic [39:0] editDig;
    logic editNeg;
    logic [3:0] cursor;
    fpmd_pwr_t pwr;
    logic saveReq;
    logic saveBusy;
    logic funcExec;
    logic alarmSeen;
    logic [31:0] toCnt;
    logic [31:0] blinkCnt;
    logic blinkOff;
    logic [31:0] ddSh;
    logic [39:0] ddBcd;
    logic [5:0] ddCnt;
    logic ddNeg;
    logic [39:0] resBcd;
    logic resNeg;
    fpmd_seg_t seg;
  } fpmd_top_st_t;

  fpmd_top_st_t s;
  fpmd_top_st_t next_s;
  fpmd_kev_t [NKEYS-1:0] kev;

  // One conditioner per key
  genvar gk;
  generate
    for (gk = 0; gk < NKEYS; gk++) begin : g_key
      fpmd_key_cond #(
        .DEB_CYC(DEB_CYC),
        .HOLD_CYC(HOLD_CYC)
      ) u_key (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .keyRaw(keysPressed[gk]),
        .keyEv(kev[gk])
      );
    end
  endgenerate

  // Add three to every BCD digit of five or more
  function automatic logic [39:0] dd_adjust(input logic [39:0] b);
    logic [39:0] r;
    r = b;
    for (int i = 0; i < NBCD; i++) begin
      if (b[i*4 +: 4] >= 4'h5) begin
        r[i*4 +: 4] = b[i*4 +: 4] + 4'h3;
      end
    end
    return r;
  endfunction

  // BCD digits back to a binary magnitude
  function automatic logic [31:0] bcd_to_bin(input logic [39:0] b);
    logic [35:0] acc;
    acc = '0;
    for (int i = NBCD - 1; i >= 0; i--) begin
      acc = 36'(acc * 36'd10) + 36'(b[i*4 +: 4]);
    end
    return acc[31:0];
  endfunction

  // Two decimal digits of a small count
  function automatic logic [7:0] dec2(input logic [6:0] v);
    logic [7:0] r;
    r = {4'(v / 7'd10), 4'(v % 7'd10)};
    return r;
  endfunction

  // Format a signed BCD value onto the five digits
  function automatic fpmd_seg_t fmt_value(input logic [39:0] bcd, input logic neg, input logic hiPage,
                                          input logic [4:0] flashMask, input logic blinkOff);
    fpmd_seg_t r;
    logic big;
    logic [4:0] mask;
    logic [3:0] d;
    big = |bcd[39:20];
    mask = flashMask;
    for (int i = 0; i < NDIG; i++) begin
      d = (hiPage && big) ? bcd[(i+NDIG)*4 +: 4] : bcd[i*4 +: 4];
      r[i] = {1'b0, fpmd_hex_seg(d)};
    end
    if (neg && !big && (bcd[19:16] == 4'h0)) begin
      r[4] = {1'b0, SEG_MINUS};
    end else if (neg) begin
      r[4][7] = 1'b1;
    end
    if (big && !hiPage) begin
      mask[4] = 1'b1;
    end
    for (int i = 0; i < NDIG; i++) begin
      if (blinkOff && mask[i]) begin
        r[i] = 8'h00;
      end
    end
    return r;
  endfunction

  // Next-state logic
  always_comb begin
    logic anyEv;
    logic anyDown;
    logic [31:0] src;
    logic [31:0] mag;
    logic [3:0] dig;
    logic [7:0] two;
    anyEv = 1'b0;
    anyDown = 1'b0;
    src = '0;
    mag = '0;
    dig = '0;
    two = '0;
    next_s = s;
    next_s.pwr.wrEn = 1'b0;
    next_s.saveReq = 1'b0;
    next_s.funcExec = 1'b0;
    for (int k = 0; k < NKEYS; k++) begin
      anyEv = anyEv | kev[k].shortPress | kev[k].holdPress;
      anyDown = anyDown | kev[k].down;
    end

    // Blink phase for flashing digits
    next_s.blinkCnt = s.blinkCnt + 32'h1;
    if (s.blinkCnt == 32'(BLINK_CYC - 1)) begin
      next_s.blinkCnt = '0;
      next_s.blinkOff = ~s.blinkOff;
    end

    // Serial binary to BCD of the value on show
    src = ((s.mode == MD_PARSEL) || (s.mode == MD_PAREDIT)) ? paramRdValue : monValue;
    if (s.ddCnt == 6'd0) begin
      next_s.ddNeg = src[31];
      next_s.ddSh = src[31] ? (32'h0 - src) : src;
      next_s.ddBcd = '0;
      next_s.ddCnt = 6'd1;
    end else begin
      {next_s.ddBcd, next_s.ddSh} = {dd_adjust(s.ddBcd), s.ddSh} << 1;
      next_s.ddCnt = s.ddCnt + 6'd1;
      if (s.ddCnt == 6'd32) begin
        next_s.resBcd = next_s.ddBcd;
        next_s.resNeg = s.ddNeg && (next_s.ddBcd != '0);
        next_s.ddCnt = 6'd0;
      end
    end

    // Inactivity timer
    if (anyDown || anyEv || (s.mode == MD_STATUS) || (s.mode == MD_WARN)) begin
      next_s.toCnt = '0;
    end else begin
      next_s.toCnt = s.toCnt + 32'h1;
    end

    if (anyEv) begin
      next_s.saveBusy = 1'b0;
    end

    next_s.alarmSeen = alarmActive;
    if (alarmActive && !s.alarmSeen) begin
      // Only a new warning switches the display
      if (s.mode != MD_WARN) begin
        next_s.prevMode = s.mode;
      end
      next_s.mode = MD_WARN;
    end else if (s.toCnt == 32'(TIMEOUT_CYC - 1)) begin
      next_s.mode = MD_STATUS;
      next_s.pageHigh = 1'b0;
    end else begin
      case (s.mode)
        MD_WARN: begin
          if (anyEv) begin
            next_s.mode = s.prevMode;
          end
        end
        MD_STATUS: begin
          if (kev[KEY_SET].holdPress) begin
            next_s.locked = ~s.locked;
          end else if (kev[KEY_UP].shortPress || kev[KEY_DOWN].shortPress) begin
            next_s.pageHigh = ~s.pageHigh;
          end else if (kev[KEY_MODE].holdPress && !s.locked) begin
            next_s.mode = MD_MONSEL;
          end
        end
        MD_MONSEL: begin
          if (kev[KEY_MODE].holdPress) begin
            next_s.mode = MD_FUNCSEL;
          end else if (kev[KEY_SET].shortPress) begin
            next_s.mode = MD_STATUS;
            next_s.pageHigh = 1'b0;
          end else if (kev[KEY_UP].shortPress) begin
            next_s.monSel = (s.monSel == MON_LAST) ? 5'h00 : s.monSel + 5'h01;
          end else if (kev[KEY_DOWN].shortPress) begin
            next_s.monSel = (s.monSel == 5'h00) ? MON_LAST : s.monSel - 5'h01;
          end
        end
        MD_FUNCSEL: begin
          if (kev[KEY_MODE].holdPress) begin
            next_s.mode = hostConnected ? MD_STATUS : MD_PARSEL;
          end else if (kev[KEY_SET].holdPress) begin
            if (s.funcSel != FUNC_SAVE) begin
              next_s.funcExec = 1'b1;
            end else if (motorMoving) begin
              next_s.saveBusy = 1'b1;
            end else begin
              next_s.saveReq = 1'b1;
            end
          end else if (kev[KEY_UP].shortPress) begin
            next_s.funcSel = (s.funcSel == FUNC_LAST) ? 4'h0 : s.funcSel + 4'h1;
          end else if (kev[KEY_DOWN].shortPress) begin
            next_s.funcSel = (s.funcSel == 4'h0) ? FUNC_LAST : s.funcSel - 4'h1;
          end
        end
        MD_PARSEL: begin
          if (kev[KEY_MODE].holdPress) begin
            next_s.mode = MD_STATUS;
          end else if (kev[KEY_SET].shortPress && !hostConnected) begin
            next_s.mode = MD_PAREDIT;
            next_s.editDig = s.resBcd;
            next_s.editNeg = s.resNeg;
            next_s.cursor = 4'h0;
          end else if (kev[KEY_UP].shortPress) begin
            next_s.paramSel = (s.paramSel == PARAM_LAST) ? 7'h00 : s.paramSel + 7'h01;
          end else if (kev[KEY_DOWN].shortPress) begin
            next_s.paramSel = (s.paramSel == 7'h00) ? PARAM_LAST : s.paramSel - 7'h01;
          end
        end
        MD_PAREDIT: begin
          dig = s.editDig[s.cursor*4 +: 4];
          if (kev[KEY_SET].shortPress) begin
            next_s.mode = MD_PARSEL;
          end else if (kev[KEY_SET].holdPress) begin
            mag = bcd_to_bin(s.editDig);
            next_s.pwr.wrEn = 1'b1;
            next_s.pwr.idx = s.paramSel;
            next_s.pwr.data = s.editNeg ? (32'h0 - mag) : mag;
            next_s.mode = MD_PARSEL;
          end else if (kev[KEY_MODE].shortPress) begin
            next_s.cursor = (s.cursor == CURSOR_LAST) ? 4'h0 : s.cursor + 4'h1;
          end else if (kev[KEY_UP].holdPress) begin
            next_s.editNeg = ~s.editNeg;
          end else if (kev[KEY_UP].shortPress) begin
            next_s.editDig[s.cursor*4 +: 4] = (dig == 4'h9) ? 4'h0 : dig + 4'h1;
          end else if (kev[KEY_DOWN].shortPress) begin
            next_s.editDig[s.cursor*4 +: 4] = (dig == 4'h0) ? 4'h9 : dig - 4'h1;
          end
        end
        default: begin
          next_s.mode = MD_STATUS;
        end
      endcase
    end

    // Display image for the mode being entered
    case (next_s.mode)
      MD_STATUS: begin
        next_s.seg = fmt_value(s.resBcd, s.resNeg, next_s.pageHigh, 5'h00, s.blinkOff);
      end
      MD_MONSEL: begin
        two = dec2({2'h0, next_s.monSel});
        next_s.seg = {{1'b0, SEG_N}, 8'h00, 8'h00, {1'b0, fpmd_hex_seg(two[7:4])}, {1'b0, fpmd_hex_seg(two[3:0])}};
      end
      MD_FUNCSEL: begin
        two = dec2({3'h0, next_s.funcSel});
        next_s.seg = {{1'b0, SEG_F}, 8'h00, 8'h00, {1'b0, fpmd_hex_seg(two[7:4])}, {1'b0, fpmd_hex_seg(two[3:0])}};
      end
      MD_PARSEL: begin
        two = dec2(next_s.paramSel);
        next_s.seg = {{1'b0, SEG_P}, 8'h00, 8'h00, {1'b0, fpmd_hex_seg(two[7:4])}, {1'b0, fpmd_hex_seg(two[3:0])}};
      end
      MD_PAREDIT: begin
        // Page follows the cursor; the cursor digit flashes
        next_s.seg = fmt_value(next_s.editDig, next_s.editNeg, next_s.cursor >= 4'h5,
                               5'(5'h01 << ((next_s.cursor >= 4'h5) ? next_s.cursor - 4'h5 : next_s.cursor)),
                               s.blinkOff);
      end
      MD_WARN: begin
        next_s.seg = {{1'b0, SEG_R}, 8'h00, {1'b0, SEG_MINUS}, {1'b0, fpmd_hex_seg(alarmCode[7:4])},
                      {1'b0, fpmd_hex_seg(alarmCode[3:0])}};
      end
      default: begin
        next_s.seg = '0;
      end
    endcase
  end

  // State register; reset gives status monitoring, unlocked, no edit
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s <= '0;
      s.monSel <= MON_DEFAULT;
      s.mode <= MD_STATUS;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign monSel = s.monSel;
  assign funcSel = s.funcSel;
  assign paramSel = s.paramSel;
  assign paramWr = s.pwr;
  assign saveReq = s.saveReq;
  assign saveBusy = s.saveBusy;
  assign funcExec = s.funcExec;
  assign dispMode = s.mode;
  assign panelLocked = s.locked;
  assign segments = s.seg;

endmodule

// file: verilog/fpmd_pkg.sv
package fpmd_pkg;

  // Clock and time base
  localparam longint unsigned CLK_HZ = 64'd125_000_000;
  localparam longint unsigned TIMEOUT_S = 64'd20;
  localparam longint unsigned HOLD_MS = 64'd1000;
  localparam longint unsigned DEB_MS = 64'd5;
  localparam longint unsigned BLINK_MS = 64'd250;
  localparam longint unsigned TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;
  localparam longint unsigned HOLD_CYC = (HOLD_MS * CLK_HZ) / 64'd1000;
  localparam longint unsigned DEB_CYC = (DEB_MS * CLK_HZ) / 64'd1000;
  localparam longint unsigned BLINK_CYC = (BLINK_MS * CLK_HZ) / 64'd1000;

  // Keys
  localparam int NKEYS = 4;
  localparam int KEY_MODE = 0;
  localparam int KEY_SET = 1;
  localparam int KEY_UP = 2;
  localparam int KEY_DOWN = 3;

  // Selection ranges and power-up values
  localparam logic [4:0] MON_DEFAULT = 5'h00;
  localparam logic [4:0] MON_LAST = 5'h12;
  localparam logic [3:0] FUNC_LAST = 4'h9;
  localparam logic [3:0] FUNC_SAVE = 4'h4;
  localparam logic [6:0] PARAM_LAST = 7'h62;
  localparam logic [3:0] CURSOR_LAST = 4'h9;
  localparam int NDIG = 5;
  localparam int NBCD = 10;

  // Segment patterns, bit order g..a
  localparam logic [6:0] SEG_BLANK = 7'h00;
  localparam logic [6:0] SEG_MINUS = 7'h40;
  localparam logic [6:0] SEG_N = 7'h54;
  localparam logic [6:0] SEG_F = 7'h71;
  localparam logic [6:0] SEG_P = 7'h73;
  localparam logic [6:0] SEG_R = 7'h50;

  typedef enum logic [2:0] {
    MD_STATUS = 3'b000,
    MD_MONSEL = 3'b001,
    MD_FUNCSEL = 3'b010,
    MD_PARSEL = 3'b011,
    MD_PAREDIT = 3'b100,
    MD_WARN = 3'b101
  } fpmd_mode_t;

  typedef struct packed {
    logic shortPress;
    logic holdPress;
    logic down;
  } fpmd_kev_t;

  typedef struct packed {
    logic wrEn;
    logic [6:0] idx;
    logic [31:0] data;
  } fpmd_pwr_t;

  // Digit 4 is the leftmost; bit 7 is the decimal point
  typedef logic [NDIG-1:0][7:0] fpmd_seg_t;

  // Hex digit to segment pattern
  function automatic logic [6:0] fpmd_hex_seg(input logic [3:0] d);
    logic [6:0] r;
    case (d)
      4'h0: r = 7'h3f;
      4'h1: r = 7'h06;
      4'h2: r = 7'h5b;
      4'h3: r = 7'h4f;
      4'h4: r = 7'h66;
      4'h5: r = 7'h6d;
      4'h6: r = 7'h7d;
      4'h7: r = 7'h07;
      4'h8: r = 7'h7f;
      4'h9: r = 7'h6f;
      4'ha: r = 7'h77;
      4'hb: r = 7'h7c;
      4'hc: r = 7'h39;
      4'hd: r = 7'h5e;
      4'he: r = 7'h79;
      default: r = 7'h71;
    endcase
    return r;
  endfunction

endpackage

// file: verilog/fpmd_key_cond.sv
`timescale 1ns/1ps
module fpmd_key_cond #(
  parameter longint unsigned DEB_CYC = fpmd_pkg::DEB_CYC,
  parameter longint unsigned HOLD_CYC = fpmd_pkg::HOLD_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Raw key pin, high while pressed
  input wire logic keyRaw,
  // Classified key events
  output fpmd_pkg::fpmd_kev_t keyEv
);
  import fpmd_pkg::*;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic stable;
    logic [31:0] debCnt;
    logic [31:0] holdCnt;
    logic holdDone;
    fpmd_kev_t ev;
  } fpmd_key_st_t;

  fpmd_key_st_t s;
  fpmd_key_st_t next_s;

  // Synchronise, debounce, then classify as short or hold
  always_comb begin
    next_s = s;
    next_s.sync1 = keyRaw;
    next_s.sync2 = s.sync1;
    next_s.ev.shortPress = 1'b0;
    next_s.ev.holdPress = 1'b0;
    if (s.sync2 != s.stable) begin
      next_s.debCnt = s.debCnt + 32'h1;
      if (s.debCnt == 32'(DEB_CYC - 1)) begin
        next_s.stable = s.sync2;
        next_s.debCnt = '0;
        next_s.holdCnt = '0;
        next_s.holdDone = 1'b0;
        // Release before the hold time counts as a short press
        if (!s.sync2 && !s.holdDone) begin
          next_s.ev.shortPress = 1'b1;
        end
      end
    end else begin
      next_s.debCnt = '0;
    end
    // Hold fires once, while the key is still down
    if (s.stable && (s.sync2 == s.stable) && !s.holdDone) begin
      next_s.holdCnt = s.holdCnt + 32'h1;
      if (s.holdCnt == 32'(HOLD_CYC - 1)) begin
        next_s.ev.holdPress = 1'b1;
        next_s.holdDone = 1'b1;
      end
    end
    next_s.ev.down = next_s.stable;
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign keyEv = s.ev;

endmodule

// file: bench/fpmd_drive_model.sv
`timescale 1ns/1ps
module fpmd_drive_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Requests from the panel
  input wire logic [6:0] paramSel,
  input wire fpmd_pkg::fpmd_pwr_t paramWr,
  input wire logic saveReq,
  input wire logic funcExec,
  // Monitor value chosen by the bench
  input wire logic [31:0] monSet,
  // Values back to the panel
  output logic [31:0] monValue,
  output logic [31:0] paramRdValue,
  // Observations for the bench
  output logic [31:0] lastWr,
  output logic [7:0] wrCnt,
  output logic [7:0] saveCnt,
  output logic [7:0] execCnt
);
  import fpmd_pkg::*;
  logic [31:0] store [0:98];

  // Working parameter store; saves are only counted, never touch it
  always @(posedge clk_sys) begin
    if (!rstn) begin
      foreach (store[i]) store[i] <= 32'h0;
      wrCnt <= 8'h0;
      saveCnt <= 8'h0;
      execCnt <= 8'h0;
      lastWr <= 32'h0;
    end else begin
      if (paramWr.wrEn === 1'b1) begin
        store[paramWr.idx] <= paramWr.data;
        lastWr <= paramWr.data;
        wrCnt <= wrCnt + 8'h1;
      end
      if (saveReq === 1'b1) saveCnt <= saveCnt + 8'h1;
      if (funcExec === 1'b1) execCnt <= execCnt + 8'h1;
    end
  end

  // Store is read without delay, as the panel expects
  assign paramRdValue = store[paramSel];
  assign monValue = monSet;
endmodule

// file: bench/fpmd_panel_ctrl_asserts.sv
`timescale 1ns/1ps
module fpmd_panel_ctrl_asserts #(
  parameter longint unsigned TIMEOUT_CYC = 64'd2000,
  parameter longint unsigned DEB_CYC = 64'd4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Inputs of the panel
  input wire logic [fpmd_pkg::NKEYS-1:0] keysPressed,
  input wire logic alarmActive,
  input wire logic hostConnected,
  input wire logic motorMoving,
  // Outputs of the panel
  input wire logic [4:0] monSel,
  input wire logic [3:0] funcSel,
  input wire logic [6:0] paramSel,
  input wire fpmd_pkg::fpmd_pwr_t paramWr,
  input wire logic saveReq,
  input wire logic saveBusy,
  input wire logic funcExec,
  input wire fpmd_pkg::fpmd_mode_t dispMode,
  input wire logic panelLocked
);
  import fpmd_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic [63:0] idleCnt;

  // Cycles spent idle in a selection or edit mode
  always_ff @(posedge clk_sys) begin
    if (!rstn || keysPressed != 4'h0 || dispMode == MD_STATUS || dispMode == MD_WARN) begin
      idleCnt <= 64'h0;
    end else begin
      idleCnt <= idleCnt + 64'h1;
    end
  end

  property p_warnEntry; $rose(alarmActive) |=> dispMode == MD_WARN; endproperty
  a_warnEntry: assert property (p_warnEntry) else $error("warning display not entered");
  property p_warnCause; $rose(dispMode == MD_WARN) |-> $past(alarmActive) && !$past(alarmActive, 2); endproperty
  a_warnCause: assert property (p_warnCause) else $error("warning display without new alarm");
  property p_wrEdit;
    paramWr.wrEn |-> $past(dispMode) == MD_PAREDIT && dispMode == MD_PARSEL && paramWr.idx == paramSel && !saveReq;
  endproperty
  a_wrEdit: assert property (p_wrEdit) else $error("working write outside edit");
  property p_saveOk; saveReq |-> !$past(motorMoving) && funcSel == FUNC_SAVE && dispMode == MD_FUNCSEL; endproperty
  a_saveOk: assert property (p_saveOk) else $error("save accepted wrongly");
  property p_busy; $rose(saveBusy) |-> $past(motorMoving) && !saveReq; endproperty
  a_busy: assert property (p_busy) else $error("busy without motion");
  property p_exec; funcExec |-> funcSel != FUNC_SAVE && !saveReq; endproperty
  a_exec: assert property (p_exec) else $error("execute pulse on save function");
  property p_host; (dispMode == MD_PARSEL && $past(dispMode) == MD_FUNCSEL) |-> !$past(hostConnected); endproperty
  a_host: assert property (p_host) else $error("parameter mode entered while host connected");
  property p_lock;
    panelLocked && $past(panelLocked) |-> $stable(monSel) && $stable(paramSel) && !paramWr.wrEn && !saveReq && !funcExec;
  endproperty
  a_lock: assert property (p_lock) else $error("locked panel changed a setting");
  property p_lockMode; $changed(panelLocked) |-> $past(dispMode) == MD_STATUS; endproperty
  a_lockMode: assert property (p_lockMode) else $error("lock toggled outside status mode");
  property p_timeout; idleCnt <= TIMEOUT_CYC + DEB_CYC + 64'd16; endproperty
  a_timeout: assert property (p_timeout) else $error("idle timeout missed");
  property p_reset; $rose(rstn) |-> dispMode == MD_STATUS && !panelLocked && monSel == MON_DEFAULT; endproperty
  a_reset: assert property (p_reset) else $error("wrong state after reset");

  // Main scenarios reached
  c_write: cover property (paramWr.wrEn);
  c_save: cover property (saveReq);
  c_busy: cover property ($rose(saveBusy));
  c_warn: cover property ($rose(dispMode == MD_WARN));
endmodule

bind fpmd_panel_ctrl fpmd_panel_ctrl_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC), .DEB_CYC(DEB_CYC)) chk_u (
  .clk_sys, .rstn, .keysPressed, .alarmActive, .hostConnected, .motorMoving, .monSel, .funcSel,
  .paramSel, .paramWr, .saveReq, .saveBusy, .funcExec, .dispMode, .panelLocked
);

// file: bench/fpmd_panel_ctrl_bench.sv
`timescale 1ns/1ps
module fpmd_panel_ctrl_bench;
  import fpmd_pkg::*;
  localparam int TOC = 2000;
  localparam int SHORTN = 12;
  localparam int HOLDN = 64;
  logic clk_sys;
  logic rstn;
  logic [NKEYS-1:0] keysPressed;
  logic alarmActive;
  logic [7:0] alarmCode;
  logic hostConnected;
  logic motorMoving;
  logic [31:0] monValue;
  logic [31:0] paramRdValue;
  logic [31:0] monSet;
  logic [31:0] lastWr;
  logic [4:0] monSel;
  logic [3:0] funcSel;
  logic [6:0] paramSel;
  fpmd_pwr_t paramWr;
  logic saveReq;
  logic saveBusy;
  logic funcExec;
  fpmd_mode_t dispMode;
  logic panelLocked;
  fpmd_seg_t segments;
  logic [7:0] wrCnt;
  logic [7:0] saveCnt;
  logic [7:0] execCnt;
  int errorCnt = 0;
  int cmpCount = 0;

  // Short counts keep the run brief
  fpmd_panel_ctrl #(.TIMEOUT_CYC(64'd2000), .HOLD_CYC(64'd50), .DEB_CYC(64'd4), .BLINK_CYC(64'd8)) dut_u (
    .clk_sys, .rstn, .keysPressed, .alarmActive, .alarmCode, .hostConnected, .motorMoving, .monValue,
    .paramRdValue, .monSel, .funcSel, .paramSel, .paramWr, .saveReq, .saveBusy, .funcExec, .dispMode,
    .panelLocked, .segments
  );
  fpmd_drive_model drv_u (
    .clk_sys, .rstn, .paramSel, .paramWr, .saveReq, .funcExec, .monSet, .monValue, .paramRdValue,
    .lastWr, .wrCnt, .saveCnt, .execCnt
  );

  // Clock at 125 MHz
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Press one key for n cycles, then let debounce and classification settle
  task automatic key(input int k, input int n);
    @(negedge clk_sys);
    keysPressed[k] = 1'b1;
    repeat (n) @(negedge clk_sys);
    keysPressed[k] = 1'b0;
    repeat (12) @(negedge clk_sys);
  endtask

  // Bounded wait for a display mode
  task automatic waitm(input fpmd_mode_t m, input int lim);
    for (int i = 0; i < lim && dispMode !== m; i++) @(negedge clk_sys);
    chk(dispMode, m);
    if (dispMode !== m) results();
  endtask

  task automatic do_reset();
    rstn = 1'b0;
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    @(negedge clk_sys);
  endtask

  task automatic s_power();
    chk(dispMode, MD_STATUS);
    chk(monSel, MON_DEFAULT);
    chk(panelLocked, 1'b0);
  endtask

  // Walk to edit, change two digits, apply, then abandon a second edit
  task automatic s_edit();
    key(KEY_MODE, HOLDN);
    waitm(MD_MONSEL, 100);
    key(KEY_UP, SHORTN);
    chk(monSel, 5'h01);
    key(KEY_DOWN, SHORTN);
    key(KEY_DOWN, SHORTN);
    chk(monSel, MON_LAST);
    key(KEY_MODE, HOLDN);
    waitm(MD_FUNCSEL, 100);
    key(KEY_MODE, HOLDN);
    waitm(MD_PARSEL, 100);
    key(KEY_UP, SHORTN);
    chk(paramSel, 7'h01);
    key(KEY_SET, SHORTN);
    waitm(MD_PAREDIT, 100);
    key(KEY_UP, SHORTN);
    key(KEY_MODE, SHORTN);
    key(KEY_UP, SHORTN);
    key(KEY_UP, HOLDN);
    key(KEY_SET, HOLDN);
    waitm(MD_PARSEL, 100);
    chk(lastWr, -32'sd11);
    chk(saveCnt, 8'h0);
    key(KEY_SET, SHORTN);
    key(KEY_DOWN, SHORTN);
    key(KEY_SET, SHORTN);
    waitm(MD_PARSEL, 100);
    chk(wrCnt, 8'h1);
  endtask

  // Save refused while moving, accepted when stopped, other function executes
  task automatic s_save();
    do_reset();
    key(KEY_MODE, HOLDN);
    key(KEY_MODE, HOLDN);
    waitm(MD_FUNCSEL, 100);
    repeat (4) key(KEY_UP, SHORTN);
    chk(funcSel, FUNC_SAVE);
    motorMoving = 1'b1;
    key(KEY_SET, HOLDN);
    chk(saveBusy, 1'b1);
    chk(saveCnt, 8'h0);
    motorMoving = 1'b0;
    key(KEY_SET, HOLDN);
    chk(saveCnt, 8'h1);
    key(KEY_UP, SHORTN);
    key(KEY_SET, HOLDN);
    chk(execCnt, 8'h1);
  endtask

  task automatic s_host();
    do_reset();
    hostConnected = 1'b1;
    repeat (3) key(KEY_MODE, HOLDN);
    waitm(MD_STATUS, 100);
    hostConnected = 1'b0;
    repeat (3) key(KEY_MODE, HOLDN);
    hostConnected = 1'b1;
    key(KEY_SET, SHORTN);
    chk(dispMode, MD_PARSEL);
    hostConnected = 1'b0;
  endtask

  task automatic s_warn();
    do_reset();
    key(KEY_MODE, HOLDN);
    waitm(MD_MONSEL, 100);
    alarmCode = 8'h3a;
    alarmActive = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(dispMode, MD_WARN);
    chk(segments[1][6:0], 7'h4f);
    chk(segments[0][6:0], 7'h77);
    key(KEY_UP, SHORTN);
    waitm(MD_MONSEL, 100);
    repeat (20) @(negedge clk_sys);
    chk(dispMode, MD_MONSEL);
    alarmActive = 1'b0;
  endtask

  task automatic s_lock();
    do_reset();
    key(KEY_SET, HOLDN);
    chk(panelLocked, 1'b1);
    key(KEY_MODE, HOLDN);
    chk(dispMode, MD_STATUS);
    key(KEY_SET, HOLDN);
    chk(panelLocked, 1'b0);
    key(KEY_SET, 30);
    chk(panelLocked, 1'b0);
    key(KEY_SET, HOLDN);
    chk(panelLocked, 1'b1);
    do_reset();
    chk(panelLocked, 1'b0);
  endtask

  task automatic s_timeout();
    do_reset();
    key(KEY_MODE, HOLDN);
    waitm(MD_MONSEL, 100);
    repeat (TOC - 100) @(negedge clk_sys);
    chk(dispMode, MD_MONSEL);
    waitm(MD_STATUS, 200);
  endtask

  // Sign handling and paging of long values in status display
  task automatic s_display();
    int on;
    int off;
    on = 0;
    off = 0;
    do_reset();
    monSet = -32'sd5;
    repeat (120) @(negedge clk_sys);
    chk(segments[4][6:0], SEG_MINUS);
    chk(segments[0][6:0], 7'h6d);
    monSet = -32'sd12345;
    repeat (120) @(negedge clk_sys);
    chk(segments[4], 8'h86);
    monSet = 32'd123456;
    repeat (120) @(negedge clk_sys);
    repeat (40) begin
      @(negedge clk_sys);
      if (segments[4][6:0] === 7'h5b) on++;
      if (segments[4][6:0] === SEG_BLANK) off++;
    end
    chk(on > 0 && off > 0, 1'b1);
    key(KEY_UP, SHORTN);
    repeat (120) @(negedge clk_sys);
    chk(segments[0][6:0], 7'h06);
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    keysPressed = 4'h0;
    alarmActive = 1'b0;
    alarmCode = 8'h00;
    hostConnected = 1'b0;
    motorMoving = 1'b0;
    monSet = 32'h0;
    do_reset();
    s_power();
    s_edit();
    s_save();
    s_host();
    s_warn();
    s_lock();
    s_timeout();
    s_display();
    results();
  end
endmodule
